// ===== logic/meter_consts.vh
/*
  Constants of the metering configuration register set: indirect addresses,
  bit positions, reset values and selector codes.
  Assumes inclusion by bare name from the design files.
*/
`ifndef METER_CONSTS_VH
`define METER_CONSTS_VH

`define ADDR_CONTROL_A      7'h0b
`define ADDR_CONTROL_B      7'h0c
`define ADDR_PULSE_TWO_NUM  7'h29
`define ADDR_PULSE_TWO_DEN  7'h2a
`define ADDR_CONTROL_C      7'h2b
`define ADDR_RESERVED_A     7'h3b
`define ADDR_RESERVED_B     7'h3c
`define ADDR_CALIBRATION    7'h3d
`define ADDR_RESERVED_C     7'h3e
`define ADDR_RESERVED_D     7'h3f

`define RST_CONTROL_A       8'h06
`define RST_CONTROL_B       8'h40
`define RST_PULSE_TWO_NUM   16'h0000
`define RST_PULSE_TWO_DEN   16'h003f
`define RST_CONTROL_C       8'h00
`define RST_RESERVED_A      8'h00
`define RST_RESERVED_B      16'h0300
`define RST_CALIBRATION     8'h00
`define RST_RESERVED_C      8'h00
`define RST_RESERVED_D      8'h00

`define BIT_SOFT_RESET      7
`define BIT_ZX_FILTER_BYP   6
`define BIT_INTEGRATOR      5
`define BIT_CHANNEL_SWAP    4
`define BIT_ADC_POWER_DOWN  3
`define BIT_PULSE_TWO_DIS   2
`define BIT_PULSE_ONE_DIS   1
`define BIT_HIGHPASS_BYP    0

`define MSB_PULSE_TWO_SRC   7
`define LSB_PULSE_TWO_SRC   6
`define MSB_PULSE_ONE_SRC   5
`define LSB_PULSE_ONE_SRC   4
`define BIT_APPARENT_RMS    3
`define BIT_RMS_SYNC        2
`define BIT_PERIOD_FREQ     1
`define BIT_WAVE_ENABLE     0

`define SRC_ACTIVE          2'h0
`define SRC_REACTIVE        2'h1
`define SRC_APPARENT_RMS    2'h2
`define SRC_RMS             2'h3

`endif

// ===== logic/source_decode.v
/*
  Decodes one pulse output's two-bit source field into a quantity code.
  Assumes the field and the apparent-or-rms bit come from registers.
*/
`timescale 1ns/1ns
`default_nettype none
`include "meter_consts.vh"

module source_decode (
  // Selection
  input  wire [1:0] source_field,
  input  wire       rms_instead,
  // Quantity: 0 active, 1 reactive, 2 apparent, 3 current rms
  output reg  [1:0] quantity
);

  always @* begin
    if (source_field[1]) begin
      quantity = rms_instead ? `SRC_RMS : `SRC_APPARENT_RMS;
    end else if (source_field[0]) begin
      quantity = `SRC_REACTIVE;
    end else begin
      quantity = `SRC_ACTIVE;
    end
  end

endmodule // source_decode

`default_nettype wire

// ===== logic/metering_config.v
/*
  Configuration register set of the metering front end, reached by the
  on-chip controller through the indirect address pointer with a write
  strobe and a combinational read port. Holds both mode registers, the
  output-two scaling pair, the third mode and calibration registers and
  the reserved registers, and decodes the controls for the datapath.
  Assumes the controller and datapath sit on the same clock.
*/
// Behaviour
// - Writing one to control A bit 7 returns all metering registers to defaults.
// - Control A bit 6 bypasses the zero-crossing low-pass filter; default off.
// - Control A bit 5 switches the di/dt integrator into the current path.
// - Control A bit 4 swaps the two ADC channels' processing paths.
// - Control A bit 3 powers down both voltage and current ADCs.
// - Control A bit 2 resets to one and disables pulse output two.
// - Control A bit 1 resets to one and disables pulse output one.
// - Control A bit 0 bypasses both channels' high-pass filters.
// - Control B bits 7:6 pick pulse two source; reset reactive.
// - Control B bits 5:4 pick pulse one source; reset active.
// - Control B bit 3 chooses apparent power or current rms for 1x sources.
// - Control B bit 2 updates current rms in step with voltage zero crossings.
// - Control B bit 1 makes the line period result a frequency.
// - Control B bit 0 enables waveform sampling; default off.
// - Pulse two numerator and denominator are 16-bit, reset zero and 0x003f.
`timescale 1ns/1ns
`default_nettype none
`include "meter_consts.vh"

module metering_config (
  // Clock and reset
  input  wire        clock,
  input  wire        rst,
  // Indirect register port
  input  wire [6:0]  metering_address_pointer,
  input  wire        write_strobe,
  input  wire [15:0] write_data,
  output reg  [15:0] read_data,
  output reg         read_hit,
  // Channel and filter controls
  output reg         zero_cross_filter_bypass,
  output reg         integrator_enable,
  output reg         channel_swap,
  output reg         adc_power_down,
  output reg         highpass_bypass,
  output reg         metering_soft_reset,
  // Pulse outputs
  output reg         pulse_two_disable,
  output reg         pulse_one_disable,
  output wire [1:0]  pulse_two_quantity,
  output wire [1:0]  pulse_one_quantity,
  output reg         apparent_or_rms_select,
  output reg  [15:0] pulse_two_numerator,
  output reg  [15:0] pulse_two_denominator,
  // Measurement modes
  output reg         rms_sync_update,
  output reg         period_or_frequency_select,
  output reg         waveform_sampling_enable,
  output reg  [7:0]  metering_control_c,
  output reg  [7:0]  calibration_setup
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.

  reg  [7:0]  control_a_q;
  reg  [7:0]  control_b_q;
  reg  [15:0] numerator_q;
  reg  [15:0] denominator_q;
  reg  [7:0]  control_c_q;
  reg  [7:0]  calibration_q;
  reg  [7:0]  reserved_a_q;
  reg  [15:0] reserved_b_q;
  reg  [7:0]  reserved_c_q;
  reg  [7:0]  reserved_d_q;
  reg         soft_reset_bit_q;
  wire        soft_reset_req;
  wire        load_defaults;

  // Per-register write enables.
  wire        write_control_a;
  wire        write_control_b;
  wire        write_numerator;
  wire        write_denominator;
  wire        write_control_c;
  wire        write_calibration;
  wire        write_reserved_a;
  wire        write_reserved_b;
  wire        write_reserved_c;
  wire        write_reserved_d;

  // A write of one to the soft reset bit is taken as a request; the bit is
  // shown set for one cycle and then the whole set returns to defaults,
  // which also clears the bit itself.
  assign soft_reset_req = write_strobe
                          && (metering_address_pointer == `ADDR_CONTROL_A)
                          && write_data[`BIT_SOFT_RESET];

  // Hardware reset and the applied soft reset share one path, so both leave
  // exactly the same contents behind.
  assign load_defaults = rst || soft_reset_bit_q;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode. Unmapped addresses enable nothing, so such writes are
  // dropped without a trace.

  assign write_control_a   = write_strobe && (metering_address_pointer == `ADDR_CONTROL_A);
  assign write_control_b   = write_strobe && (metering_address_pointer == `ADDR_CONTROL_B);
  assign write_numerator   = write_strobe && (metering_address_pointer == `ADDR_PULSE_TWO_NUM);
  assign write_denominator = write_strobe && (metering_address_pointer == `ADDR_PULSE_TWO_DEN);
  assign write_control_c   = write_strobe && (metering_address_pointer == `ADDR_CONTROL_C);
  assign write_calibration = write_strobe && (metering_address_pointer == `ADDR_CALIBRATION);
  assign write_reserved_a  = write_strobe && (metering_address_pointer == `ADDR_RESERVED_A);
  assign write_reserved_b  = write_strobe && (metering_address_pointer == `ADDR_RESERVED_B);
  assign write_reserved_c  = write_strobe && (metering_address_pointer == `ADDR_RESERVED_C);
  assign write_reserved_d  = write_strobe && (metering_address_pointer == `ADDR_RESERVED_D);

  ////////////////////////////////////////////////////////////////////////////
  // Register processes. The defaults win over any write in the same cycle,
  // so a write right behind a soft reset request is lost.

  // The request bit lives for one cycle; the defaults it triggers clear it.
  always @(posedge clock) begin
    if (load_defaults) begin
      soft_reset_bit_q <= 1'b0;
    end else begin
      soft_reset_bit_q <= soft_reset_req;
    end
  end

  // The rest of the byte is ignored on a soft reset request, so the
  // controls do not flicker for the one cycle before the defaults land.
  always @(posedge clock) begin
    if (load_defaults) begin
      control_a_q <= `RST_CONTROL_A;
    end else if (write_control_a && !write_data[`BIT_SOFT_RESET]) begin
      control_a_q <= {1'b0, write_data[6:0]};
    end
  end

  // Both source fields and the apparent-or-rms bit land in one write, so a
  // change of quantity never passes through a mixed setting.
  always @(posedge clock) begin
    if (load_defaults) begin
      control_b_q <= `RST_CONTROL_B;
    end else if (write_control_b) begin
      control_b_q <= write_data[7:0];
    end
  end

  // The scaling pair is written whole, each half of the ratio in one write.
  always @(posedge clock) begin
    if (load_defaults) begin
      numerator_q <= `RST_PULSE_TWO_NUM;
    end else if (write_numerator) begin
      numerator_q <= write_data;
    end
  end

  always @(posedge clock) begin
    if (load_defaults) begin
      denominator_q <= `RST_PULSE_TWO_DEN;
    end else if (write_denominator) begin
      denominator_q <= write_data;
    end
  end

  // Control C and the calibration byte are only stored here; their meaning
  // belongs to the datapath.
  always @(posedge clock) begin
    if (load_defaults) begin
      control_c_q <= `RST_CONTROL_C;
    end else if (write_control_c) begin
      control_c_q <= write_data[7:0];
    end
  end

  always @(posedge clock) begin
    if (load_defaults) begin
      calibration_q <= `RST_CALIBRATION;
    end else if (write_calibration) begin
      calibration_q <= write_data[7:0];
    end
  end

  // Reserved locations store what is written; keeping them at their
  // defaults is left to software.
  always @(posedge clock) begin
    if (load_defaults) begin
      reserved_a_q <= `RST_RESERVED_A;
    end else if (write_reserved_a) begin
      reserved_a_q <= write_data[7:0];
    end
  end

  always @(posedge clock) begin
    if (load_defaults) begin
      reserved_b_q <= `RST_RESERVED_B;
    end else if (write_reserved_b) begin
      reserved_b_q <= write_data;
    end
  end

  always @(posedge clock) begin
    if (load_defaults) begin
      reserved_c_q <= `RST_RESERVED_C;
    end else if (write_reserved_c) begin
      reserved_c_q <= write_data[7:0];
    end
  end

  always @(posedge clock) begin
    if (load_defaults) begin
      reserved_d_q <= `RST_RESERVED_D;
    end else if (write_reserved_d) begin
      reserved_d_q <= write_data[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port. Narrow registers sit in the low bits; unmapped reads give
  // zero with read_hit low.

  always @* begin
    read_data = 16'h0000;
    read_hit  = 1'b1;
    case (metering_address_pointer)
      `ADDR_CONTROL_A: begin
        read_data = {8'h00, soft_reset_bit_q, control_a_q[6:0]};
      end
      `ADDR_CONTROL_B: begin
        read_data = {8'h00, control_b_q};
      end
      `ADDR_PULSE_TWO_NUM: begin
        read_data = numerator_q;
      end
      `ADDR_PULSE_TWO_DEN: begin
        read_data = denominator_q;
      end
      `ADDR_CONTROL_C: begin
        read_data = {8'h00, control_c_q};
      end
      `ADDR_CALIBRATION: begin
        read_data = {8'h00, calibration_q};
      end
      `ADDR_RESERVED_A: begin
        read_data = {8'h00, reserved_a_q};
      end
      `ADDR_RESERVED_B: begin
        read_data = reserved_b_q;
      end
      `ADDR_RESERVED_C: begin
        read_data = {8'h00, reserved_c_q};
      end
      `ADDR_RESERVED_D: begin
        read_data = {8'h00, reserved_d_q};
      end
      default: begin
        read_hit = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Controls to the datapath.

  always @* begin
    metering_soft_reset        = soft_reset_bit_q;
    zero_cross_filter_bypass   = control_a_q[`BIT_ZX_FILTER_BYP];
    integrator_enable          = control_a_q[`BIT_INTEGRATOR];
    channel_swap               = control_a_q[`BIT_CHANNEL_SWAP];
    adc_power_down             = control_a_q[`BIT_ADC_POWER_DOWN];
    pulse_two_disable          = control_a_q[`BIT_PULSE_TWO_DIS];
    pulse_one_disable          = control_a_q[`BIT_PULSE_ONE_DIS];
    highpass_bypass            = control_a_q[`BIT_HIGHPASS_BYP];
    apparent_or_rms_select     = control_b_q[`BIT_APPARENT_RMS];
    rms_sync_update            = control_b_q[`BIT_RMS_SYNC];
    period_or_frequency_select = control_b_q[`BIT_PERIOD_FREQ];
    waveform_sampling_enable   = control_b_q[`BIT_WAVE_ENABLE];
    pulse_two_numerator        = numerator_q;
    pulse_two_denominator      = denominator_q;
    metering_control_c         = control_c_q;
    calibration_setup          = calibration_q;
  end

  // Both outputs share the apparent-or-rms bit, so the mixed combination
  // that software must avoid cannot be encoded here anyway.
  source_decode pulse_two_dec (
    .source_field (control_b_q[`MSB_PULSE_TWO_SRC:`LSB_PULSE_TWO_SRC]),
    .rms_instead  (control_b_q[`BIT_APPARENT_RMS]),
    .quantity     (pulse_two_quantity)
  );

  source_decode pulse_one_dec (
    .source_field (control_b_q[`MSB_PULSE_ONE_SRC:`LSB_PULSE_ONE_SRC]),
    .rms_instead  (control_b_q[`BIT_APPARENT_RMS]),
    .quantity     (pulse_one_quantity)
  );

endmodule // metering_config

`default_nettype wire

// ===== verif/metering_config_checker.sv
/* Assertions on the ports of metering_config.
   Assumes one clock and a synchronous reset. */
`timescale 1ns/1ns
`default_nettype none
module metering_config_checker (
  // Clock, reset and register port
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [6:0]  metering_address_pointer,
  input wire logic        write_strobe,
  input wire logic [15:0] write_data,
  input wire logic [15:0] read_data,
  // Decoded outputs
  input wire logic        metering_soft_reset,
  input wire logic        pulse_two_disable,
  input wire logic        pulse_one_disable,
  input wire logic        highpass_bypass,
  input wire logic [1:0]  pulse_two_quantity,
  input wire logic [1:0]  pulse_one_quantity,
  input wire logic        rms_sync_update,
  input wire logic [15:0] pulse_two_numerator,
  input wire logic [15:0] pulse_two_denominator
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  // A write on the edge that applies a soft reset is lost, so it is left out.
  wire       ok = write_strobe && !metering_soft_reset;
  wire [6:0] ad = metering_address_pointer;
  a_soft_pulse: assert property (ok && ad == 7'h0b && write_data[7] |=> metering_soft_reset)
    else $error("soft reset missing");
  a_soft_clears: assert property (metering_soft_reset |=> !metering_soft_reset
    && pulse_two_numerator == 16'h0000 && pulse_two_denominator == 16'h003f)
    else $error("soft reset not restored");
  a_ctrl_a_write: assert property (ok && ad == 7'h0b && !write_data[7] |=>
    {pulse_two_disable, pulse_one_disable, highpass_bypass} == $past(write_data[2:0]))
    else $error("control A outputs wrong");
  a_num_write: assert property (ok && ad == 7'h29 |=>
    pulse_two_numerator == $past(write_data))
    else $error("numerator write lost");
  a_rms_sync: assert property (ok && ad == 7'h0c |=>
    rms_sync_update == $past(write_data[2]))
    else $error("rms sync bit wrong");
  a_two_source: assert property (ad == 7'h0c |-> pulse_two_quantity ==
    (read_data[7] ? {1'b1, read_data[3]} : {1'b0, read_data[6]}))
    else $error("pulse two source wrong");
  a_one_source: assert property (ad == 7'h0c |-> pulse_one_quantity ==
    (read_data[5] ? {1'b1, read_data[3]} : {1'b0, read_data[4]}))
    else $error("pulse one source wrong");
  a_reset_values: assert property ($past(rst) |-> pulse_two_disable && pulse_one_disable
    && pulse_two_quantity == 2'h1 && pulse_one_quantity == 2'h0)
    else $error("reset values wrong");
endmodule // metering_config_checker
bind metering_config metering_config_checker u_chk (.*);
`default_nettype wire

// ===== verif/host_model.sv
/* Controller model driving the indirect register port.
   Assumes each task is entered just after a falling clock edge. */
`timescale 1ns/1ns
`default_nettype none
module host_model (
  // Clock
  input  wire logic        clock,
  // Register port
  output var  logic [6:0]  metering_address_pointer,
  output var  logic        write_strobe,
  output var  logic [15:0] write_data
);
  initial write_strobe = 1'b0;
  initial metering_address_pointer = 7'h00;
  initial write_data = 16'h0000;
  // Hold keeps the strobe up so that the next write lands on the very next edge.
  task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic hold);
    metering_address_pointer = a;
    write_data = d;
    write_strobe = 1'b1;
    @(negedge clock);
    if (!hold) begin
      write_strobe = 1'b0;
      write_data = ~d;
      @(negedge clock);
    end
  endtask
  task automatic sel(input logic [6:0] a);
    metering_address_pointer = a;
    @(negedge clock);
  endtask
endmodule // host_model
`default_nettype wire

// ===== verif/metering_config_tb.sv
/* Bench for metering_config: table of writes, then soft reset, unmapped and reset cases.
   Assumes host_model on the port and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module metering_config_tb;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [6:0]  metering_address_pointer, a;
  logic        write_strobe, read_hit, metering_soft_reset, apparent_or_rms_select;
  logic        zero_cross_filter_bypass, integrator_enable, channel_swap, adc_power_down;
  logic        pulse_two_disable, pulse_one_disable, highpass_bypass, rms_sync_update;
  logic        period_or_frequency_select, waveform_sampling_enable;
  logic [1:0]  pulse_two_quantity, pulse_one_quantity;
  logic [7:0]  metering_control_c, calibration_setup;
  logic [15:0] write_data, read_data, pulse_two_numerator, pulse_two_denominator, d, e;
  int          bad_count = 0;
  int          num_checks = 0;
  // Row: address, data written, expected quantities of pulse two and pulse one.
  logic [26:0] rows [15] = '{{7'h29, 16'ha5c3, 4'h0}, {7'h2a, 16'hffff, 4'h0},
    {7'h2b, 16'h1234, 4'h0}, {7'h3d, 16'h00ff, 4'h0}, {7'h3b, 16'h0000, 4'h0},
    {7'h3c, 16'h0300, 4'h0}, {7'h0b, 16'h007f, 4'h0}, {7'h0b, 16'h0000, 4'h0},
    {7'h0b, 16'h002a, 4'h0}, {7'h0c, 16'h0000, 4'h0}, {7'h0c, 16'h005f, 4'h5},
    {7'h0c, 16'h00a0, 4'ha}, {7'h0c, 16'h00a8, 4'hf}, {7'h0c, 16'h0065, 4'h6},
    {7'h0c, 16'h008a, 4'hc}};
  logic [22:0] dflt [10] = '{{7'h0b, 16'h0006}, {7'h0c, 16'h0040}, {7'h29, 16'h0000},
    {7'h2a, 16'h003f}, {7'h2b, 16'h0000}, {7'h3b, 16'h0000}, {7'h3c, 16'h0300},
    {7'h3d, 16'h0000}, {7'h3e, 16'h0000}, {7'h3f, 16'h0000}};
  wire [15:0]  ctl_a = {9'h000, zero_cross_filter_bypass, integrator_enable, channel_swap,
    adc_power_down, pulse_two_disable, pulse_one_disable, highpass_bypass};
  wire [15:0]  ctl_b = {12'h000, apparent_or_rms_select, rms_sync_update,
    period_or_frequency_select, waveform_sampling_enable};
  wire [15:0]  ctl_q = {12'h000, pulse_two_quantity, pulse_one_quantity};
  metering_config u_dut (.*);
  host_model u_host (.*);
  always #50 clock = ~clock;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check_defaults();
    foreach (dflt[i]) begin
      u_host.sel(dflt[i][22:16]);
      chk(read_data, dflt[i][15:0]);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (5) @(negedge clock);
    rst = 1'b0;
    check_defaults();
    foreach (rows[i]) begin
      a = rows[i][26:20];
      d = rows[i][19:4];
      // Only the scaling pair and one reserved register are 16 bits wide.
      e = (a == 7'h29 || a == 7'h2a || a == 7'h3c) ? d : {8'h00, d[7:0]};
      u_host.wr(a, d, 1'b0);
      u_host.sel(a);
      chk(read_data, e);
      chk({15'h0000, read_hit}, 16'h0001);
      if (a == 7'h29) chk(pulse_two_numerator, e);
      if (a == 7'h2a) chk(pulse_two_denominator, e);
      if (a == 7'h2b) chk({8'h00, metering_control_c}, e);
      if (a == 7'h3d) chk({8'h00, calibration_setup}, e);
      if (a == 7'h0b) chk(ctl_a, e);
      if (a == 7'h0c) chk(ctl_b, e & 16'h000f);
      if (a == 7'h0c) chk(ctl_q, {12'h000, rows[i][3:0]});
    end
    // The write on the edge right after the request must lose to the defaults.
    u_host.wr(7'h0b, 16'h0080, 1'b1);
    chk({15'h0000, metering_soft_reset}, 16'h0001);
    chk(read_data & 16'h0080, 16'h0080);
    u_host.wr(7'h29, 16'h1111, 1'b0);
    chk({15'h0000, metering_soft_reset}, 16'h0000);
    check_defaults();
    u_host.wr(7'h05, 16'hbeef, 1'b0);
    u_host.sel(7'h05);
    chk({15'h0000, read_hit}, 16'h0000);
    chk(read_data, 16'h0000);
    check_defaults();
    u_host.wr(7'h0c, 16'h00ff, 1'b0);
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    check_defaults();
    complete_run();
  end
endmodule // metering_config_tb
`default_nettype wire
